/* shared/scr_pkg.sv */
// Register map, field layout and carrier types of the clock and serializer bank
package scr_pkg;

  localparam int          ADDR_W         = 12;
  localparam int          DATA_W         = 8;

  // Offsets
  localparam logic [11:0] CLK_CTRL_ADDR  = 12'h030;
  localparam logic [11:0] CLK_STAT_ADDR  = 12'h031;
  localparam logic [11:0] SR_DELAY_ADDR  = 12'h032;
  localparam logic [11:0] ANALOG_MISC_CTRL_ADDR  = 12'h033;
  localparam logic [11:0] CLAMP_ADDR     = 12'h034;
  localparam logic [11:0] SERIALIZER_CONFIG_ADDR   = 12'h040;
  localparam logic [11:0] CAL_A_ADDR     = 12'h050;
  localparam logic [11:0] CAL_B_ADDR     = 12'h051;
  localparam logic [11:0] CAL_BACK_ADDR  = 12'h057;
  localparam logic [11:0] PAT_OVR_ADDR   = 12'h058;
  localparam logic [11:0] CAL_VEC_ADDR   = 12'h05a;
  localparam logic [11:0] CAL_STAT_ADDR  = 12'h05b;
  localparam logic [11:0] T_CAL_ADDR     = 12'h066;

  // Reset values
  localparam logic [7:0]  CLK_CTRL_RST   = 8'hc0;
  localparam logic [7:0]  SR_DELAY_RST   = 8'h80;
  localparam logic [7:0]  ANALOG_MISC_CTRL_RST   = 8'hc3;
  localparam logic [7:0]  CLAMP_RST      = 8'h2f;
  localparam logic [7:0]  SERIALIZER_CONFIG_RST    = 8'h04;
  localparam logic [7:0]  CAL_A_RST      = 8'h06;
  localparam logic [7:0]  CAL_B_RST      = 8'hf4;
  localparam logic [7:0]  CAL_BACK_RST   = 8'h10;
  localparam logic [7:0]  PAT_OVR_RST    = 8'h00;
  localparam logic [7:0]  CAL_VEC_RST    = 8'h00;
  localparam logic [7:0]  T_CAL_RST      = 8'h02;

  // Field positions
  localparam int          SEEN_CLR_BIT   = 5;
  localparam int          MARG_CLR_BIT   = 4;
  localparam int          SEEN_FLAG_BIT  = 7;
  localparam int          MARG_FLAG_BIT  = 6;
  localparam logic [5:0]  STAT_FIXED     = 6'h07;
  localparam int          SYNC_PD_BIT    = 2;
  localparam int          CLAMP_BIT      = 5;

  // Delay step size
  localparam int          DELAY_STEP_PS  = 20;
  localparam int          DELAY_MAX      = 15;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [11:0] addr;
    logic [7:0] wdata;
  } scr_req_t;

  typedef struct packed {
    logic [3:0] sysref_delay_step;
    logic       sync_diff_powerdown;
    logic       input_clamp_on;
    logic [3:0] lane_preemphasis_level;
  } scr_ctrl_t;

endpackage

/* hdl/scr_sticky_flag.sv */
// Sticky status flag cleared by a one-then-zero write pair
`timescale 1ns/100ps
module scr_sticky_flag (
  input  wire logic clk_i,
  input  wire logic nrst_i,
  input  wire logic event_i,
  input  wire logic clr_bit_i,
  output logic      flag_o
);

  logic clr_armed;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      clr_armed <= 1'b0;
    end else begin
      clr_armed <= clr_bit_i;
    end
  end

  // Set wins over the falling clear bit
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      flag_o <= 1'b0;
    end else if (event_i) begin
      flag_o <= 1'b1;
    end else if (clr_armed && !clr_bit_i) begin
      flag_o <= 1'b0;
    end
  end

endmodule

/* hdl/scr_regs.sv */
// Clock and serializer configuration and status register bank
`timescale 1ns/100ps
module scr_regs (
  input  wire logic             clk_i,
  input  wire logic             nrst_i,
  input  wire scr_pkg::scr_req_t req_i,
  input  wire logic             sysref_i,
  input  wire logic             sysref_marginal_i,
  input  wire logic [7:0]       cal_status_i,
  output logic [7:0]            rdata_o,
  output logic                  rvalid_o,
  output scr_pkg::scr_ctrl_t    ctrl_o
);

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] clk_ctrl, sr_delay, analog_misc_ctrl, clamp, serializer_config;
  logic [7:0] cal_a, cal_b, cal_back, pat_ovr, cal_vec, t_cal;
  logic [2:0] sr_sync;
  logic [1:0] marg_sync;
  logic       seen_flag, marg_flag;
  logic       sysref_rise, marg_rise;
  logic [7:0] next_rdata;

  // Pin inputs pass two flops before edge logic
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sr_sync   <= 3'h0;
      marg_sync <= 2'h0;
    end else begin
      sr_sync   <= {sr_sync[1:0], sysref_i};
      marg_sync <= {marg_sync[0], sysref_marginal_i};
    end
  end

  assign sysref_rise = sr_sync[1] & ~sr_sync[2];
  // marginal edge only counts with an edge
  assign marg_rise   = sysref_rise & marg_sync[1];

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic hit(input logic [11:0] a);
    return req_i.wr && req_i.addr == a;
  endfunction

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      clk_ctrl <= scr_pkg::CLK_CTRL_RST;
      sr_delay <= scr_pkg::SR_DELAY_RST;
      analog_misc_ctrl <= scr_pkg::ANALOG_MISC_CTRL_RST;
      clamp    <= scr_pkg::CLAMP_RST;
      serializer_config  <= scr_pkg::SERIALIZER_CONFIG_RST;
      cal_a    <= scr_pkg::CAL_A_RST;
      cal_b    <= scr_pkg::CAL_B_RST;
      cal_back <= scr_pkg::CAL_BACK_RST;
      pat_ovr  <= scr_pkg::PAT_OVR_RST;
      cal_vec  <= scr_pkg::CAL_VEC_RST;
      t_cal    <= scr_pkg::T_CAL_RST;
    end else begin
      // clear controls held in control register
      if (hit(scr_pkg::CLK_CTRL_ADDR)) clk_ctrl <= req_i.wdata;
      if (hit(scr_pkg::SR_DELAY_ADDR)) sr_delay <= req_i.wdata;
      if (hit(scr_pkg::ANALOG_MISC_CTRL_ADDR)) analog_misc_ctrl <= req_i.wdata;
      if (hit(scr_pkg::CLAMP_ADDR))    clamp    <= req_i.wdata;
      if (hit(scr_pkg::SERIALIZER_CONFIG_ADDR))  serializer_config  <= req_i.wdata;
      if (hit(scr_pkg::CAL_A_ADDR))    cal_a    <= req_i.wdata;
      if (hit(scr_pkg::CAL_B_ADDR))    cal_b    <= req_i.wdata;
      if (hit(scr_pkg::CAL_BACK_ADDR)) cal_back <= req_i.wdata;
      if (hit(scr_pkg::PAT_OVR_ADDR))  pat_ovr  <= req_i.wdata;
      if (hit(scr_pkg::CAL_VEC_ADDR))  cal_vec  <= req_i.wdata;
      if (hit(scr_pkg::T_CAL_ADDR))    t_cal    <= req_i.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // seen flag sticky with clear pair
  scr_sticky_flag u_seen (
    .clk_i     (clk_i),
    .nrst_i    (nrst_i),
    .event_i   (sysref_rise),
    .clr_bit_i (clk_ctrl[scr_pkg::SEEN_CLR_BIT]),
    .flag_o    (seen_flag)
  );

  // marginal flag sticky with clear pair
  scr_sticky_flag u_marg (
    .clk_i     (clk_i),
    .nrst_i    (nrst_i),
    .event_i   (marg_rise),
    .clr_bit_i (clk_ctrl[scr_pkg::MARG_CLR_BIT]),
    .flag_o    (marg_flag)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_rdata = 8'h00;
    case (req_i.addr)
      scr_pkg::CLK_CTRL_ADDR: next_rdata = clk_ctrl;
      scr_pkg::CLK_STAT_ADDR: next_rdata = {seen_flag, marg_flag,
                                            scr_pkg::STAT_FIXED};
      scr_pkg::SR_DELAY_ADDR: next_rdata = sr_delay;
      scr_pkg::ANALOG_MISC_CTRL_ADDR: next_rdata = analog_misc_ctrl;
      scr_pkg::CLAMP_ADDR:    next_rdata = clamp;
      scr_pkg::SERIALIZER_CONFIG_ADDR:  next_rdata = serializer_config;
      scr_pkg::CAL_A_ADDR:    next_rdata = cal_a;
      scr_pkg::CAL_B_ADDR:    next_rdata = cal_b;
      scr_pkg::CAL_BACK_ADDR: next_rdata = cal_back;
      scr_pkg::PAT_OVR_ADDR:  next_rdata = pat_ovr;
      scr_pkg::CAL_VEC_ADDR:  next_rdata = cal_vec;
      scr_pkg::CAL_STAT_ADDR: next_rdata = cal_status_i;
      scr_pkg::T_CAL_ADDR:    next_rdata = t_cal;
      default:                next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o  <= 8'h00;
      rvalid_o <= 1'b0;
    end else begin
      rvalid_o <= req_i.rd;
      rdata_o  <= req_i.rd ? next_rdata : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Analog controls registered so outputs come from flops
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl_o <= '0;
    end else begin
      // delay step field, 20 ps per step in the analog delay line
      ctrl_o.sysref_delay_step      <= sr_delay[3:0];
      ctrl_o.sync_diff_powerdown    <= analog_misc_ctrl[scr_pkg::SYNC_PD_BIT];
      ctrl_o.input_clamp_on         <= clamp[scr_pkg::CLAMP_BIT];
      ctrl_o.lane_preemphasis_level <= serializer_config[3:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  a_seen_sets: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    sysref_rise |=> seen_flag)
    else $error("seen flag not set after sysref edge");

  a_seen_clear: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    $fell(clk_ctrl[scr_pkg::SEEN_CLR_BIT]) && !sysref_rise |=> !seen_flag)
    else $error("seen flag not cleared by write pair");

  a_marg_sets: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    marg_rise |=> marg_flag)
    else $error("marginal flag not set");

  a_marg_clear: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    $fell(clk_ctrl[scr_pkg::MARG_CLR_BIT]) && !marg_rise |=> !marg_flag)
    else $error("marginal flag not cleared by write pair");

  a_stat_fixed: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    req_i.rd && req_i.addr == scr_pkg::CLK_STAT_ADDR
      |=> rvalid_o && rdata_o[5:0] == 6'h07)
    else $error("status low bits not fixed");

  a_delay_out: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    hit(scr_pkg::SR_DELAY_ADDR)
      |=> ##1 ctrl_o.sysref_delay_step == $past(req_i.wdata[3:0], 2))
    else $error("delay step not applied");

  a_sync_pd: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    hit(scr_pkg::ANALOG_MISC_CTRL_ADDR)
      |=> ##1 ctrl_o.sync_diff_powerdown == $past(req_i.wdata[2], 2))
    else $error("sync powerdown not applied");

  // Output flops lag one edge, so skip the edge that leaves reset
  a_clamp_pre: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    $past(nrst_i) |->
    ctrl_o.input_clamp_on == $past(clamp[5]) &&
    ctrl_o.lane_preemphasis_level == $past(serializer_config[3:0]))
    else $error("clamp or preemphasis output mismatch");

  a_sticky_hold: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    seen_flag && !$fell(clk_ctrl[scr_pkg::SEEN_CLR_BIT]) |=> seen_flag)
    else $error("seen flag dropped without clear pair");

endmodule

/* verification/scr_regs_tb.sv */
// Self-checking bench for the clock and serializer register bank
`timescale 1ns/100ps
module scr_regs_tb;
  logic               clk_i;
  logic               nrst_i;
  scr_pkg::scr_req_t  req_i;
  logic               sysref_i;
  logic               sysref_marginal_i;
  logic [7:0]         cal_status_i;
  logic [7:0]         rdata_o;
  logic               rvalid_o;
  scr_pkg::scr_ctrl_t ctrl_o;
  int                 n_fail;
  int                 cmp_count;
  // Every stored register with its reset value
  logic [11:0]        rw_addr [11];
  logic [7:0]         rw_rst  [11];

  scr_regs u_dut (
    .clk_i             (clk_i),
    .nrst_i            (nrst_i),
    .req_i             (req_i),
    .sysref_i          (sysref_i),
    .sysref_marginal_i (sysref_marginal_i),
    .cal_status_i      (cal_status_i),
    .rdata_o           (rdata_o),
    .rvalid_o          (rvalid_o),
    .ctrl_o            (ctrl_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_i);
    req_i <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_i);
    req_i <= '0;
  endtask

  // Answer is registered, so look one edge after the request is taken
  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    req_i <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_i);
    req_i <= '0;
    #1;
    chk("rvalid", 8'h01, {7'h00, rvalid_o});
    chk($sformatf("rdata at %h", a), exp, rdata_o);
  endtask

  // Marginal level is held with the edge so both pass the synchroniser
  task automatic pulse(input logic m);
    @(posedge clk_i);
    sysref_i          <= 1'b1;
    sysref_marginal_i <= m;
    idle(6);
    sysref_i          <= 1'b0;
    sysref_marginal_i <= 1'b0;
    idle(3);
  endtask

  task automatic clr(input logic [7:0] mask);
    wr(scr_pkg::CLK_CTRL_ADDR, 8'hc0 | mask);
    wr(scr_pkg::CLK_CTRL_ADDR, 8'hc0);
    idle(3);
  endtask

  task automatic ctl(input logic [3:0] dl, input logic pd, input logic cl,
                     input logic [3:0] pe);
    #1;
    chk("delay", {4'h0, dl}, {4'h0, ctrl_o.sysref_delay_step});
    chk("sync pd", {7'h00, pd}, {7'h00, ctrl_o.sync_diff_powerdown});
    chk("clamp", {7'h00, cl}, {7'h00, ctrl_o.input_clamp_on});
    chk("preemph", {4'h0, pe}, {4'h0, ctrl_o.lane_preemphasis_level});
  endtask

  task automatic test_done();
    $display("Comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Whole run is about 150 cycles; this leaves wide margin
  initial begin
    #50000;
    n_fail++;
    test_done();
  end

  initial begin
    rw_addr = '{12'h030, 12'h032, 12'h033, 12'h034, 12'h040, 12'h050,
                12'h051, 12'h057, 12'h058, 12'h05a, 12'h066};
    rw_rst  = '{8'hc0, 8'h80, 8'hc3, 8'h2f, 8'h04, 8'h06,
                8'hf4, 8'h10, 8'h00, 8'h00, 8'h02};
    n_fail            = 0;
    cmp_count         = 0;
    nrst_i            = 1'b0;
    req_i             = '0;
    sysref_i          = 1'b0;
    sysref_marginal_i = 1'b0;
    cal_status_i      = 8'h5a;
    idle(2);
    nrst_i <= 1'b1;
    idle(2);
    ctl(4'h0, 1'b0, 1'b1, 4'h4);
    for (int i = 0; i < 11; i++) begin
      rd(rw_addr[i], rw_rst[i]);
    end
    rd(scr_pkg::CLK_STAT_ADDR, 8'h07);
    $display("Test reset values done");
    // Inverted reset values flip every stored bit
    for (int i = 0; i < 11; i++) begin
      wr(rw_addr[i], ~rw_rst[i]);
    end
    for (int i = 0; i < 11; i++) begin
      rd(rw_addr[i], ~rw_rst[i]);
    end
    idle(2);
    ctl(4'hf, 1'b1, 1'b0, 4'hb);
    wr(scr_pkg::CLK_STAT_ADDR, 8'hff);
    rd(scr_pkg::CLK_STAT_ADDR, 8'h07);
    wr(scr_pkg::CAL_STAT_ADDR, 8'h00);
    rd(scr_pkg::CAL_STAT_ADDR, 8'h5a);
    wr(12'h035, 8'hff);
    rd(12'h035, 8'h00);
    rd(12'h041, 8'h00);
    $display("Test write and read back done");
    // Clear bits left set by the inverted pattern would fire early clears
    wr(scr_pkg::CLK_CTRL_ADDR, scr_pkg::CLK_CTRL_RST);
    // receiver powered again before SYNC~ is used
    wr(scr_pkg::ANALOG_MISC_CTRL_ADDR, scr_pkg::ANALOG_MISC_CTRL_RST);
    idle(2);
    ctl(4'hf, 1'b0, 1'b0, 4'hb);
    pulse(1'b0);
    rd(scr_pkg::CLK_STAT_ADDR, 8'h87);
    clr(8'h10);
    rd(scr_pkg::CLK_STAT_ADDR, 8'h87);
    clr(8'h20);
    rd(scr_pkg::CLK_STAT_ADDR, 8'h07);
    $display("Test edge flag done");
    pulse(1'b1);
    rd(scr_pkg::CLK_STAT_ADDR, 8'hc7);
    clr(8'h10);
    rd(scr_pkg::CLK_STAT_ADDR, 8'h87);
    clr(8'h20);
    rd(scr_pkg::CLK_STAT_ADDR, 8'h07);
    $display("Test marginal flag done");
    test_done();
  end
endmodule
